// ==== src/rpk_pkg.sv ====
// Constants shared by the radar panel key controller.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package rpk_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned WARMUP_S        = 90;
  localparam int unsigned WARMUP_TICKS    = WARMUP_S * 1000_000 / TICK_US;
  localparam int unsigned DEBOUNCE_TICKS  = 4;
  localparam int unsigned REPEAT_DELAY_MS = 500;
  localparam int unsigned REPEAT_RATE_MS  = 100;

  // Key indices on the keypad bus
  localparam int NUM_KEYS     = 21;
  localparam int K_STANDBY    = 0;
  localparam int K_TRANSMIT   = 1;
  localparam int K_TUNE       = 2;
  localparam int K_GAIN       = 3;
  localparam int K_SEA        = 4;
  localparam int K_BEARING    = 5;
  localparam int K_MARKER     = 6;
  localparam int K_RANGE      = 7;
  localparam int K_BACKLIGHT  = 8;
  localparam int K_LATLON     = 9;
  localparam int K_HEADING    = 10;
  localparam int K_ENLARGE    = 11;
  localparam int K_IR         = 12;
  localparam int K_CONTRAST   = 13;
  localparam int K_RINGS      = 14;
  localparam int K_OFFSET     = 15;
  localparam int K_RAIN       = 16;
  localparam int K_HOLD       = 17;
  localparam int K_ALARM      = 18;
  localparam int K_UP         = 19;
  localparam int K_DOWN       = 20;

  // Adjustment values
  localparam int unsigned BEARING_FULL   = 360;
  localparam logic [8:0]  BEARING_FINE   = 9'h001;
  localparam logic [8:0]  BEARING_COARSE = 9'h00A;
  localparam logic [7:0]  LEVEL_MAX      = 8'hFF;
  localparam logic [7:0]  LEVEL_RESET    = 8'h80;
  localparam logic [4:0]  SEA_MAX        = 5'h1F;
  localparam logic [6:0]  SEA_LIMIT      = 7'h60;
  localparam logic [1:0]  BACKLIGHT_LAST = 2'h3;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_KEYINJ = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LEVELS = 8'h0C;
  localparam logic [7:0] REG_MARKS  = 8'h10;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PWR_OFF  = 4'b0001,
    PWR_WARM = 4'b0010,
    PWR_STBY = 4'b0100,
    PWR_XMIT = 4'b1000
  } rpk_pwr_e;

  typedef enum logic [7:0] {
    SEL_TUNE     = 8'b00000001,
    SEL_GAIN     = 8'b00000010,
    SEL_SEA      = 8'b00000100,
    SEL_BEARING  = 8'b00001000,
    SEL_MARKER   = 8'b00010000,
    SEL_RANGE    = 8'b00100000,
    SEL_CONTRAST = 8'b01000000,
    SEL_ALARM    = 8'b10000000
  } rpk_sel_e;

  localparam logic [1:0] GUARD_OFF  = 2'h0;
  localparam logic [1:0] GUARD_FULL = 2'h1;
  localparam logic [1:0] GUARD_AHEAD = 2'h2;

endpackage

// ==== src/rpk_key_ctrl.sv ====
// Radar front-panel key interpreter with AXI4-Lite status and control.
// Assumes active-low keypad pins from outside the clock domain and
// video-side inputs (zone hit, echo range) on the system clock.
// Summary of operation
// - Standby key from off powers up, shows banner
// - After warm-up, banner replaced by ready
// - Transmit key when ready enables transmitter
// - Standby key while transmitting returns to standby
// - Both power keys together switch everything off
// - Tune key selects tuning, bar graph follows
// - Gain key selects gain, up/down step it
// - Bearing line: 1 degree steps, coarse when held
// - Range marker readout, ring only below range
// - Range item steps through range scales
// - Backlight key cycles off and three levels
// - Position key toggles readout, navigator not checked
// - Heading marker hidden while key held, and outside standby and transmit
// - Interference reject toggles with indicator
// - Enlarge, rings, rain suppression each toggle
// - Offset key toggles quarter-radius downward shift
// - Hold key freezes picture while held
// - Guard zone cycles full, ahead, off; ranged
// - Target inside set guard zone sounds alarm while transmitting
// - Sea suppression adjustable in 32 steps
// - Sea suppression tapers to nothing by three miles
// - Contrast key selects contrast adjustment
`timescale 1ns/1ps
`default_nettype none
module rpk_key_ctrl
  import rpk_pkg::*;
#(
  parameter int unsigned TICK_LEN    = rpk_pkg::TICK_CYCLES,
  parameter int unsigned WARMUP_LEN  = rpk_pkg::WARMUP_TICKS,
  parameter int unsigned RANGE_SCALES = 8
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Keypad pins, active low
  input  wire logic [rpk_pkg::NUM_KEYS-1:0] key_n,
  // System inputs
  input  wire logic        nav_present,
  input  wire logic        target_in_zone,
  input  wire logic [6:0]  echo_range,
  // Power and transmitter
  output logic             unit_power_on,
  output logic             transmit_enable,
  output logic             show_targets,
  output logic             banner_warmup,
  output logic             banner_ready,
  output logic             banner_standby,
  // Overlay
  output logic      [7:0]  select_marker,
  output logic      [7:0]  bargraph_value,
  output logic      [8:0]  bearing_value,
  output logic             bearing_line_on,
  output logic      [7:0]  marker_value,
  output logic             marker_readout_on,
  output logic             marker_ring_on,
  output logic      [2:0]  range_scale,
  output logic      [1:0]  backlight_level,
  output logic             latlon_on,
  output logic             heading_marker_on,
  output logic             ir_on,
  output logic             enlarge_on,
  output logic             rings_on,
  output logic             rain_on,
  output logic             offset_on,
  output logic             picture_freeze,
  output logic      [1:0]  guard_mode,
  output logic      [7:0]  guard_range,
  output logic             alarm_sound,
  // Receiver settings
  output logic      [7:0]  tune_level,
  output logic      [7:0]  gain_level,
  output logic      [7:0]  contrast_level,
  output logic      [4:0]  sea_level,
  output logic      [11:0] sea_taper,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import rpk_pkg::*;

  localparam int TW = $clog2(TICK_LEN + 1);
  localparam int WW = $clog2(WARMUP_LEN + 1);

  rpk_pwr_e           pwr_reg;
  rpk_sel_e           sel_reg;
  logic [TW-1:0]      tick_cnt_reg;
  logic               tick;
  logic [WW-1:0]      warm_cnt_reg;
  logic [NUM_KEYS-1:0] sync1_reg, sync2_reg, deb_reg, deb_prev_reg;
  logic [NUM_KEYS-1:0] press, hw_press;
  logic [NUM_KEYS-1:0] inject_reg;
  logic               ctrl_keys_en_reg;
  logic [9:0]         rep_cnt_reg;
  logic               rep_tick;
  logic               step_up, step_down, coarse;
  logic               both_power, active;

  // Millisecond tick divider
  always_ff @(posedge aclk) begin
    if (!aresetn || tick_cnt_reg == TW'(TICK_LEN - 1)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
    end
  end
  assign tick = (tick_cnt_reg == TW'(TICK_LEN - 1));

  // Synchronise, debounce and edge-detect every key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      deb_prev_reg <= '0;
    end else begin
      sync1_reg    <= ~key_n;
      sync2_reg    <= sync1_reg;
      deb_prev_reg <= deb_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_KEYS; gi++) begin : g_deb
      logic [DEBOUNCE_TICKS-1:0] hist_reg;
      // Level only moves after a full window of agreeing samples
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hist_reg      <= '0;
          deb_reg[gi]   <= 1'b0;
        end else if (tick) begin
          hist_reg <= {hist_reg[DEBOUNCE_TICKS-2:0], sync2_reg[gi]};
          if (&hist_reg) begin
            deb_reg[gi] <= 1'b1;
          end else if (~|hist_reg) begin
            deb_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign hw_press = deb_reg & ~deb_prev_reg;
  assign press    = (ctrl_keys_en_reg ? hw_press : '0) | inject_reg;

  // Auto-repeat while up or down stays held
  always_ff @(posedge aclk) begin
    if (!aresetn || !(deb_reg[K_UP] ^ deb_reg[K_DOWN])) begin
      rep_cnt_reg <= '0;
    end else if (tick) begin
      if (rep_cnt_reg == 10'(REPEAT_DELAY_MS)) begin
        rep_cnt_reg <= 10'(REPEAT_DELAY_MS - REPEAT_RATE_MS);
      end else begin
        rep_cnt_reg <= rep_cnt_reg + 10'h001;
      end
    end
  end
  assign rep_tick  = tick && rep_cnt_reg == 10'(REPEAT_DELAY_MS);
  assign coarse    = rep_tick;
  assign step_up   = active && (press[K_UP] || (rep_tick && deb_reg[K_UP]));
  assign step_down = active &&
                     (press[K_DOWN] || (rep_tick && deb_reg[K_DOWN]));

  // Power pair: one pressed while the other is down, or both pressed in one cycle
  assign both_power = (press[K_STANDBY] && (deb_reg[K_TRANSMIT] ||
                       press[K_TRANSMIT])) ||
                      (press[K_TRANSMIT] && deb_reg[K_STANDBY]);
  assign active = (pwr_reg == PWR_STBY) || (pwr_reg == PWR_XMIT);

  // Power state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_reg <= PWR_OFF;
    end else if (both_power) begin
      pwr_reg <= PWR_OFF;
    end else begin
      case (pwr_reg)
        PWR_OFF:  if (press[K_STANDBY]) pwr_reg <= PWR_WARM;
        PWR_WARM: if (tick && warm_cnt_reg == WW'(WARMUP_LEN - 1))
                    pwr_reg <= PWR_STBY;
        PWR_STBY: if (press[K_TRANSMIT]) pwr_reg <= PWR_XMIT;
        PWR_XMIT: if (press[K_STANDBY]) pwr_reg <= PWR_STBY;
        default:  pwr_reg <= PWR_OFF;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pwr_reg != PWR_WARM) begin
      warm_cnt_reg <= '0;
    end else if (tick) begin
      warm_cnt_reg <= warm_cnt_reg + WW'(1);
    end
  end

  // Standby banner once the transmitter has been stood down
  always_ff @(posedge aclk) begin
    if (!aresetn || pwr_reg != PWR_STBY) begin
      banner_standby <= 1'b0;
    end else begin
      banner_standby <= banner_standby || banner_ready == 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      banner_ready <= 1'b0;
    end else if (pwr_reg == PWR_OFF || both_power) begin
      banner_ready <= 1'b0;
    end else if (pwr_reg == PWR_WARM) begin
      banner_ready <= tick && warm_cnt_reg == WW'(WARMUP_LEN - 1);
    end else if (pwr_reg == PWR_XMIT) begin
      banner_ready <= 1'b0;
    end
  end

  assign unit_power_on   = (pwr_reg != PWR_OFF);
  assign banner_warmup   = (pwr_reg == PWR_WARM);
  assign transmit_enable = (pwr_reg == PWR_XMIT);
  assign show_targets    = (pwr_reg == PWR_XMIT);

  // Selection of the up/down target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_reg <= SEL_TUNE;
    end else if (active) begin
      if (press[K_TUNE])          sel_reg <= SEL_TUNE;
      else if (press[K_GAIN])     sel_reg <= SEL_GAIN;
      else if (press[K_SEA])      sel_reg <= SEL_SEA;
      else if (press[K_BEARING])  sel_reg <= SEL_BEARING;
      else if (press[K_MARKER])   sel_reg <= SEL_MARKER;
      else if (press[K_RANGE])    sel_reg <= SEL_RANGE;
      else if (press[K_CONTRAST]) sel_reg <= SEL_CONTRAST;
      else if (press[K_ALARM])    sel_reg <= SEL_ALARM;
    end
  end
  assign select_marker = sel_reg;

  // Saturating 8-bit step helper
  function automatic logic [7:0] step8(input logic [7:0] v,
                                        input logic up, input logic dn);
    logic [7:0] r;
    r = v;
    if (up && v != LEVEL_MAX) r = v + 8'h01;
    else if (dn && v != 8'h00) r = v - 8'h01;
    return r;
  endfunction

  // Level adjustments
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tune_level     <= LEVEL_RESET;
      gain_level     <= LEVEL_RESET;
      contrast_level <= LEVEL_RESET;
      marker_value   <= 8'h00;
      guard_range    <= 8'h00;
      sea_level      <= 5'h00;
      range_scale    <= 3'h0;
    end else begin
      case (sel_reg)
        SEL_TUNE:     tune_level <= step8(tune_level, step_up,
                                          step_down);
        SEL_GAIN:     gain_level <= step8(gain_level, step_up,
                                          step_down);
        SEL_CONTRAST: contrast_level <= step8(contrast_level, step_up,
                                              step_down);
        SEL_MARKER:   if (marker_readout_on)
                        marker_value <= step8(marker_value, step_up,
                                              step_down);
        SEL_ALARM:    if (guard_mode != GUARD_OFF)
                        guard_range <= step8(guard_range, step_up,
                                             step_down);
        SEL_SEA: begin
          if (step_up && sea_level != SEA_MAX)
            sea_level <= sea_level + 5'h01;
          else if (step_down && sea_level != 5'h00)
            sea_level <= sea_level - 5'h01;
        end
        SEL_RANGE: begin
          // Scales step on presses only; repeat would overshoot
          if (press[K_UP] && active &&
              range_scale != 3'(RANGE_SCALES - 1))
            range_scale <= range_scale + 3'h1;
          else if (press[K_DOWN] && active && range_scale != 3'h0)
            range_scale <= range_scale - 3'h1;
        end
        default: ;
      endcase
    end
  end

  assign bargraph_value = (sel_reg == SEL_GAIN)     ? gain_level :
                          (sel_reg == SEL_CONTRAST) ? contrast_level :
                          (sel_reg == SEL_SEA)      ? {sea_level, 3'h0} :
                                                      tune_level;

  // Bearing line, wraps through a full circle
  logic [8:0] bstep;
  assign bstep = coarse ? BEARING_COARSE : BEARING_FINE;
  always_ff @(posedge aclk) begin
    if (!aresetn || !unit_power_on) begin
      bearing_value   <= 9'h000;
      bearing_line_on <= 1'b0;
    end else begin
      if (active && press[K_BEARING])
        bearing_line_on <= !(bearing_line_on &&
                             sel_reg == SEL_BEARING);
      if (sel_reg == SEL_BEARING && bearing_line_on) begin
        if (step_up) begin
          if (bearing_value + bstep >= 9'(BEARING_FULL))
            bearing_value <= bearing_value + bstep - 9'(BEARING_FULL);
          else
            bearing_value <= bearing_value + bstep;
        end else if (step_down) begin
          if (bearing_value < bstep)
            bearing_value <= bearing_value + 9'(BEARING_FULL) - bstep;
          else
            bearing_value <= bearing_value - bstep;
        end
      end
    end
  end

  // Toggles and cycling options; all cleared when switched off
  always_ff @(posedge aclk) begin
    if (!aresetn || !unit_power_on) begin
      marker_readout_on <= 1'b0;
      backlight_level   <= 2'h0;
      latlon_on         <= 1'b0;
      ir_on             <= 1'b0;
      enlarge_on        <= 1'b0;
      rings_on          <= 1'b0;
      rain_on           <= 1'b0;
      offset_on         <= 1'b0;
      guard_mode        <= GUARD_OFF;
    end else if (active) begin
      if (press[K_MARKER])
        marker_readout_on <= !(marker_readout_on &&
                               sel_reg == SEL_MARKER);
      if (press[K_BACKLIGHT])
        backlight_level <= (backlight_level == BACKLIGHT_LAST) ? 2'h0 :
                           backlight_level + 2'h1;
      if (press[K_LATLON])  latlon_on  <= !latlon_on;
      if (press[K_IR])      ir_on      <= !ir_on;
      if (press[K_ENLARGE]) enlarge_on <= !enlarge_on;
      if (press[K_RINGS])   rings_on   <= !rings_on;
      if (press[K_RAIN])    rain_on    <= !rain_on;
      if (press[K_OFFSET])  offset_on  <= !offset_on;
      if (press[K_ALARM])
        guard_mode <= (guard_mode == GUARD_OFF)  ? GUARD_FULL :
                      (guard_mode == GUARD_FULL) ? GUARD_AHEAD :
                                                   GUARD_OFF;
    end
  end

  // Ring only drawn when the marker lies inside the displayed range
  assign marker_ring_on = marker_readout_on &&
                          ({range_scale, 5'h1F} > marker_value);
  assign heading_marker_on = active && !deb_reg[K_HEADING];
  assign picture_freeze    = active && deb_reg[K_HOLD];

  // Guard alarm and sea taper, registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_sound <= 1'b0;
      sea_taper   <= 12'h000;
    end else begin
      alarm_sound <= transmit_enable && guard_mode != GUARD_OFF &&
                     target_in_zone;
      if (echo_range >= SEA_LIMIT)
        sea_taper <= 12'h000;
      else
        sea_taper <= 12'(sea_level) *
                     (12'(SEA_LIMIT) - 12'(echo_range));
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic        aw_got_reg, w_got_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;

  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign wr_fire       = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == REG_CTRL ||
                         aw_addr_reg == REG_KEYINJ) ? RESP_OKAY :
                                                      RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register and one-cycle injected key presses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_keys_en_reg <= 1'b1;
      inject_reg       <= '0;
    end else begin
      inject_reg <= '0;
      if (wr_fire && aw_addr_reg == REG_CTRL && w_strb_reg[0]) begin
        ctrl_keys_en_reg <= w_data_reg[0];
      end else if (wr_fire && aw_addr_reg == REG_KEYINJ) begin
        inject_reg <= w_data_reg[NUM_KEYS-1:0];
      end
    end
  end

  // AXI4-Lite read path, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        s_axi_rdata <= {31'h0, ctrl_keys_en_reg};
      end else if (s_axi_araddr == REG_KEYINJ) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr == REG_STATUS) begin
        s_axi_rdata <= {nav_present, alarm_sound, guard_mode,
                        offset_on, rain_on, rings_on, enlarge_on,
                        ir_on, latlon_on, backlight_level,
                        sel_reg, banner_standby, banner_ready,
                        pwr_reg, 6'h00};
      end else if (s_axi_araddr == REG_LEVELS) begin
        s_axi_rdata <= {tune_level, gain_level, contrast_level,
                        3'h0, sea_level};
      end else if (s_axi_araddr == REG_MARKS) begin
        s_axi_rdata <= {bearing_value, marker_value, guard_range,
                        range_scale, 4'h0};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

endmodule // rpk_key_ctrl
`default_nettype wire

// ==== sim/rpk_keypad.sv ====
// Keypad partner: the operator holds keys, pins read low when held.
// Assumes the bench sets the held mask on the clock's rising edge.
`timescale 1ns/1ps
`default_nettype none
module rpk_keypad (
  // Operator side
  input  wire logic [rpk_pkg::NUM_KEYS-1:0] held,
  // Keypad pins
  output logic      [rpk_pkg::NUM_KEYS-1:0] key_n
);
  // Pull-ups: a released key reads high
  assign key_n = ~held;
endmodule // rpk_keypad
`default_nettype wire

// ==== sim/rpk_key_ctrl_assertions.sv ====
// Checker of output relations at the rpk_key_ctrl ports.
// Assumes one clock domain; bound to every rpk_key_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module rpk_key_ctrl_chk import rpk_pkg::*;
  #(parameter int unsigned TICK_LEN = 10, WARMUP_LEN = 5) (
  // Clock, reset, video inputs
  input wire logic        aclk, aresetn, target_in_zone,
  input wire logic [6:0]  echo_range,
  // Design outputs
  input wire logic        unit_power_on, transmit_enable, show_targets,
  input wire logic        banner_warmup, banner_ready, heading_marker_on,
  input wire logic        picture_freeze, marker_readout_on, marker_ring_on,
  input wire logic        alarm_sound,
  input wire logic [7:0]  marker_value,
  input wire logic [2:0]  range_scale,
  input wire logic [1:0]  backlight_level, guard_mode,
  input wire logic [4:0]  sea_level,
  input wire logic [11:0] sea_taper);
  // Slack covers a partial first tick
  localparam int WMIN = (WARMUP_LEN - 1) * TICK_LEN - 2;
  localparam int WMAX = (WARMUP_LEN + 2) * TICK_LEN;
  int warm_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || !banner_warmup) warm_cnt <= 32'h0;
    else warm_cnt <= warm_cnt + 32'h1;
  end
  sequence warm_end; banner_warmup ##1 !banner_warmup; endsequence
  AST_READY: assert property (warm_end |-> warm_cnt >= WMIN
    ##[0:1] banner_ready) else $error("ready late or warm-up short");
  AST_WARM_LEN: assert property (warm_cnt <= WMAX)
    else $error("warm-up too long");
  AST_XMIT: assert property (transmit_enable |-> unit_power_on
    && show_targets) else $error("transmit without power");
  AST_OFF_DARK: assert property (!unit_power_on |->
    !heading_marker_on && !picture_freeze) else $error("overlay while off");
  AST_RING: assert property (marker_ring_on == (marker_readout_on &&
    {range_scale, 5'h1F} > marker_value)) else $error("ring wrong");
  AST_BACKLIGHT: assert property ($changed(backlight_level)
    && unit_power_on |-> backlight_level == $past(backlight_level) + 2'h1)
    else $error("backlight step wrong");
  AST_ALARM: assert property (alarm_sound |-> $past(target_in_zone)
    && $past(transmit_enable) && $past(guard_mode) != GUARD_OFF)
    else $error("alarm without cause");
  AST_TAPER: assert property (sea_taper == ($past(echo_range) < SEA_LIMIT ?
    12'($past(sea_level)) * (12'(SEA_LIMIT) - 12'($past(echo_range)))
    : 12'h000)) else $error("taper wrong");
endmodule // rpk_key_ctrl_chk
bind rpk_key_ctrl rpk_key_ctrl_chk #(.TICK_LEN(TICK_LEN),
  .WARMUP_LEN(WARMUP_LEN)) u_rpk_key_ctrl_chk (.*);
`default_nettype wire

// ==== sim/rpk_key_ctrl_tb_top.sv ====
// Bench for rpk_key_ctrl: AXI4-Lite master, key rows, then hand cases.
// Assumes rpk_keypad for held keys and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module rpk_key_ctrl_tb_top;
  import rpk_pkg::*;
  typedef struct {int k, lsb, w, v;} rpk_row_s;
  logic aclk = 1'h0, aresetn = 1'h0, target_in_zone = 1'h0, nav_present = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [6:0] echo_range = 7'h20;
  logic [NUM_KEYS-1:0] held = 21'h0, key_n;
  logic unit_power_on, transmit_enable, show_targets, banner_warmup, banner_ready;
  logic banner_standby, bearing_line_on, marker_readout_on, marker_ring_on, ir_on;
  logic latlon_on, heading_marker_on, enlarge_on, rings_on, rain_on, offset_on;
  logic picture_freeze, alarm_sound, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] select_marker, bargraph_value, marker_value, guard_range;
  logic [7:0] tune_level, gain_level, contrast_level;
  logic [8:0] bearing_value;
  logic [4:0] sea_level;
  logic [2:0] range_scale;
  logic [1:0] backlight_level, guard_mode, s_axi_bresp, s_axi_rresp, r;
  logic [11:0] sea_taper;
  int n_errors = 0, n_tests = 0;
  rpk_row_s rows[20] = '{'{K_TRANSMIT,6,4,PWR_XMIT},
    '{K_IR,23,1,1}, '{K_IR,23,1,0}, '{K_ENLARGE,24,1,1},
    '{K_RINGS,25,1,1}, '{K_RAIN,26,1,1}, '{K_LATLON,22,1,1},
    '{K_OFFSET,27,1,1}, '{K_OFFSET,27,1,0}, '{K_BACKLIGHT,20,2,1},
    '{K_BACKLIGHT,20,2,2}, '{K_BACKLIGHT,20,2,3}, '{K_BACKLIGHT,20,2,0},
    '{K_ALARM,28,2,GUARD_FULL}, '{K_ALARM,28,2,GUARD_AHEAD},
    '{K_ALARM,28,2,GUARD_OFF}, '{K_TUNE,12,8,SEL_TUNE},
    '{K_GAIN,12,8,SEL_GAIN}, '{K_CONTRAST,12,8,SEL_CONTRAST},
    '{K_SEA,12,8,SEL_SEA}};
  always #50 aclk = ~aclk;
  rpk_key_ctrl #(.TICK_LEN(10), .WARMUP_LEN(5)) u_rpk_key_ctrl (.*);
  rpk_keypad u_rpk_keypad (.held(held), .key_n(key_n));
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One read or one write; waits on each channel's own handshake
  task automatic ax(input logic we, input logic [7:0] a,
                    input logic [31:0] wd);
    logic [2:0] p, t;
    p = {1'h1, we, 1'h1};
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
    {s_axi_arvalid, s_axi_rready} <= {2{!we}};
    while (p != 3'h0) begin
      @(negedge aclk);
      t = we ? {s_axi_awready, s_axi_wready, s_axi_bvalid}
             : {s_axi_arready, 1'h0, s_axi_rvalid};
      r = we ? s_axi_bresp : s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (t[2]) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (t[1]) s_axi_wvalid <= 1'h0;
      if (t[0]) {s_axi_bready, s_axi_rready} <= 2'h0;
      p &= ~t;
    end
  endtask
  task automatic press(input logic [31:0] m);
    ax(1'h1, REG_KEYINJ, m);
    repeat (3) @(negedge aclk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin : main
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    ax(1'h0, REG_LEVELS, 32'h0);
    chk(d, 32'h80808000);
    $display("test reset done");
    press(1 << K_IR);
    press(1 << K_STANDBY);
    chk(32'({unit_power_on, banner_warmup, ir_on}), 32'h6);
    for (int i = 0; i < 200 && banner_ready !== 1'h1; i++) @(negedge aclk);
    chk(32'({banner_ready, banner_warmup}), 32'h2);
    foreach (rows[i]) begin
      press(1 << rows[i].k);
      ax(1'h0, REG_STATUS, 32'h0);
      chk((d >> rows[i].lsb) & ((32'h1 << rows[i].w) - 32'h1), 32'(rows[i].v));
    end
    $display("test rows done");
    press(1 << K_UP);
    chk(32'({sea_level, sea_taper}), 32'h1040);
    press(1 << K_BEARING);
    press(1 << K_DOWN);
    chk(32'({bearing_line_on, bearing_value}), 32'h367);
    press(1 << K_ALARM);
    @(posedge aclk);
    target_in_zone <= 1'h1;
    held <= (21'h1 << K_HEADING) | (21'h1 << K_HOLD);
    repeat (100) @(negedge aclk);
    chk(32'({alarm_sound, heading_marker_on, picture_freeze}), 32'h5);
    @(posedge aclk);
    {held, target_in_zone} <= 22'h0;
    repeat (100) @(negedge aclk);
    chk(32'({alarm_sound, heading_marker_on, picture_freeze}), 32'h2);
    press(1 << K_STANDBY);
    chk(32'({transmit_enable, banner_standby}), 32'h1);
    press((1 << K_STANDBY) | (1 << K_TRANSMIT));
    chk(32'({unit_power_on, banner_ready, banner_standby}), 32'h0);
    ax(1'h1, REG_STATUS, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    ax(1'h0, 8'h40, 32'h0);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    $display("test hand done");
    complete_run();
  end
  initial begin : watchdog
    repeat (20000) @(posedge aclk);
    n_errors++;
    complete_run();
  end
endmodule // rpk_key_ctrl_tb_top
`default_nettype wire
